// [include/adx_map.svh]
// Constants for the converter, power, watchdog and clock instruction executor
`ifndef ADX_MAP_SVH
`define ADX_MAP_SVH

// ----------------------------------------
// Opcodes (10-bit instruction words)
// ----------------------------------------
`define ADX_OP_NOP        10'h000
`define ADX_OP_BKP_VDET   10'h002
`define ADX_OP_PD_TEST    10'h003
`define ADX_OP_BKP_ALL    10'h008
`define ADX_OP_PD_ARM     10'h05b
`define ADX_OP_WR_CCTL    10'h204
`define ADX_OP_WR_CLK     10'h216
`define ADX_OP_WR_CMP     10'h239
`define ADX_OP_RD_CCTL    10'h244
`define ADX_OP_RD_LOW     10'h249
`define ADX_OP_RD_CLK     10'h252
`define ADX_OP_RD_PAIR    10'h279
`define ADX_OP_DONE_TEST  10'h287
`define ADX_OP_CER_SEL    10'h29a
`define ADX_OP_RC_SEL     10'h29b
`define ADX_OP_WDT_STOPEN 10'h29c
`define ADX_OP_CONV_START 10'h29f
`define ADX_OP_WDT_RST    10'h2a0

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ADX_MODE_BIT      3
`define ADX_CONV_IE_BIT   2
`define ADX_CCTL_RST      4'h0
`define ADX_CLK_RST       4'h0
`define ADX_CMP_RST       8'h00

`endif

// [include/adx_pkg.sv]
// Types for the instruction executor
package adx_pkg;
   typedef enum logic [1:0] {
      ADX_CLK_RING    = 2'h0,
      ADX_CLK_CERAMIC = 2'h1,
      ADX_CLK_RC      = 2'h2
   } adx_clksrc_type;

   typedef enum logic [2:0] {
      ADX_ST_RUN  = 3'b001,
      ADX_ST_SKIP = 3'b010,
      ADX_ST_BKP  = 3'b100
   } adx_state_type;
endpackage

// [rtl/adx_decode.sv]
// Opcode decoder for the executor
`timescale 1ns/1ps
`include "adx_map.svh"

module adx_decode (
   input  wire logic [9:0] i_op,          // Instruction word
   output logic            o_nop,         // No-operation
   output logic            o_bkp_vdet,    // Backup, detector kept
   output logic            o_bkp_all,     // Backup, all stopped
   output logic            o_pd_arm,      // Power-down arming
   output logic            o_pd_test,     // Power-down flag test
   output logic            o_rd_pair,     // Result pair read
   output logic            o_rd_low,      // Low bits read
   output logic            o_wr_cmp,      // Comparator write
   output logic            o_rd_cctl,     // Control read
   output logic            o_wr_cctl,     // Control write
   output logic            o_conv_start,  // Converter start
   output logic            o_done_test,   // Done flag test
   output logic            o_wdt_stopen,  // Watchdog stop enable
   output logic            o_wdt_rst,     // Watchdog restart
   output logic            o_cer_sel,     // Ceramic select
   output logic            o_rc_sel,      // RC select
   output logic            o_rd_clk,      // Clock reg read
   output logic            o_wr_clk       // Clock reg write
);
   always_comb begin
      o_nop        = (i_op == `ADX_OP_NOP);
      o_bkp_vdet   = (i_op == `ADX_OP_BKP_VDET);
      o_bkp_all    = (i_op == `ADX_OP_BKP_ALL);
      o_pd_arm     = (i_op == `ADX_OP_PD_ARM);
      o_pd_test    = (i_op == `ADX_OP_PD_TEST);
      o_rd_pair    = (i_op == `ADX_OP_RD_PAIR);
      o_rd_low     = (i_op == `ADX_OP_RD_LOW);
      o_wr_cmp     = (i_op == `ADX_OP_WR_CMP);
      o_rd_cctl    = (i_op == `ADX_OP_RD_CCTL);
      o_wr_cctl    = (i_op == `ADX_OP_WR_CCTL);
      o_conv_start = (i_op == `ADX_OP_CONV_START);
      o_done_test  = (i_op == `ADX_OP_DONE_TEST);
      o_wdt_stopen = (i_op == `ADX_OP_WDT_STOPEN);
      o_wdt_rst    = (i_op == `ADX_OP_WDT_RST);
      o_cer_sel    = (i_op == `ADX_OP_CER_SEL);
      o_rc_sel     = (i_op == `ADX_OP_RC_SEL);
      o_rd_clk     = (i_op == `ADX_OP_RD_CLK);
      o_wr_clk     = (i_op == `ADX_OP_WR_CLK);
   end
endmodule // adx_decode

// [rtl/adx_exec.sv]
// Executor for converter, power-down, watchdog and clock instructions
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "adx_map.svh"

module adx_exec
   import adx_pkg::*;
#(
   parameter int DATA_W = 4                    // Accumulator width
) (
   input  wire logic                  i_mclk,          // Instruction clock
   input  wire logic                  i_rst_n,         // Async reset, low
   input  wire logic                  i_valid,         // Instruction issued
   input  wire logic [9:0]            i_op,            // Instruction word
   input  wire logic [DATA_W-1:0]     i_acc_a,         // Register A
   input  wire logic [DATA_W-1:0]     i_acc_b,         // Register B
   input  wire logic [9:0]            i_conv_result,   // Converter result
   input  wire logic                  i_conv_done,     // Done event pulse
   input  wire logic                  i_conv_ie,       // Interrupt ctrl bit 2
   input  wire logic                  i_pd_flag,       // Power-down flag
   input  wire logic                  i_wdt_flag_set,  // Watchdog flag one set
   input  wire logic                  i_wake,          // Leave backup
   output logic                       o_pc_inc,        // Advance counter
   output logic                       o_a_we,          // Write register A
   output logic [DATA_W-1:0]          o_a_data,        // Data for A
   output logic                       o_b_we,          // Write register B
   output logic [DATA_W-1:0]          o_b_data,        // Data for B
   output logic [3:0]                 o_conv_control,  // Converter control
   output logic [7:0]                 o_comparator,    // Comparator register
   output logic                       o_conv_start,    // Start conversion
   output logic                       o_cmp_start,     // Start comparison
   output logic                       o_conv_done_flag,// Done flag
   output logic                       o_backup,        // In RAM backup
   output logic                       o_vdet_keep,     // Detector kept on
   output logic                       o_wdt_flag_one,  // Watchdog flag one
   output logic                       o_wdt_stop,      // Watchdog stopped
   output adx_pkg::adx_clksrc_type    o_clk_src,       // Clock source
   output logic                       o_ring_stop,     // Ring osc stopped
   output logic [3:0]                 o_clock_control  // Clock control reg
);
   import adx_pkg::*;

   // Only a 4-bit accumulator pair is served
   if (DATA_W != 4) begin : g_bad_data_w
      $error("adx_exec supports DATA_W of 4 only");
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic d_nop, d_bkp_vdet, d_bkp_all, d_pd_arm, d_pd_test, d_rd_pair;
   logic d_rd_low, d_wr_cmp, d_rd_cctl, d_wr_cctl, d_start, d_done_test;
   logic d_wdt_stopen, d_wdt_rst, d_cer, d_rc, d_rd_clk, d_wr_clk;

   adx_decode u_dec (
      .i_op         (i_op),
      .o_nop        (d_nop),
      .o_bkp_vdet   (d_bkp_vdet),
      .o_bkp_all    (d_bkp_all),
      .o_pd_arm     (d_pd_arm),
      .o_pd_test    (d_pd_test),
      .o_rd_pair    (d_rd_pair),
      .o_rd_low     (d_rd_low),
      .o_wr_cmp     (d_wr_cmp),
      .o_rd_cctl    (d_rd_cctl),
      .o_wr_cctl    (d_wr_cctl),
      .o_conv_start (d_start),
      .o_done_test  (d_done_test),
      .o_wdt_stopen (d_wdt_stopen),
      .o_wdt_rst    (d_wdt_rst),
      .o_cer_sel    (d_cer),
      .o_rc_sel     (d_rc),
      .o_rd_clk     (d_rd_clk),
      .o_wr_clk     (d_wr_clk)
   );

   // ----------------------------------------
   // Sequencing state
   // ----------------------------------------
   adx_state_type state_r;
   logic          pd_armed_r;
   logic          wdt_armed_r;
   logic          mode;
   logic          run;
   logic          skip_now;
   logic          exec;

   assign mode = o_conv_control[`ADX_MODE_BIT];
   assign run  = (state_r == ADX_ST_RUN) && i_valid;
   assign exec = run;

   always_comb begin
      skip_now = 1'b0;
      if (exec) begin
         if (d_done_test && !i_conv_ie && o_conv_done_flag) skip_now = 1'b1;
         if (d_pd_test && i_pd_flag) skip_now = 1'b1;
         if (d_wdt_rst && o_wdt_flag_one) skip_now = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ADX_ST_RUN;
      end else begin
         case (state_r)
            ADX_ST_RUN: begin
               if (exec && pd_armed_r && (d_bkp_vdet || d_bkp_all)) state_r <= ADX_ST_BKP;
               else if (skip_now) state_r <= ADX_ST_SKIP;
            end
            ADX_ST_SKIP: begin
               if (i_valid) state_r <= ADX_ST_RUN;
            end
            ADX_ST_BKP: begin
               if (i_wake) state_r <= ADX_ST_RUN;
            end
            default: state_r <= ADX_ST_RUN;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) pd_armed_r <= 1'b0;
      else if (i_valid && state_r != ADX_ST_BKP) pd_armed_r <= exec && d_pd_arm;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) wdt_armed_r <= 1'b0;
      else if (i_valid && state_r != ADX_ST_BKP) wdt_armed_r <= exec && d_wdt_stopen;
   end

   // ----------------------------------------
   // Backup outputs
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_backup    <= 1'b0;
         o_vdet_keep <= 1'b1;
      end else if (exec && pd_armed_r && d_bkp_vdet) begin
         o_backup    <= 1'b1;
         o_vdet_keep <= 1'b1;
      end else if (exec && pd_armed_r && d_bkp_all) begin
         o_backup    <= 1'b1;
         o_vdet_keep <= 1'b0;
      end else if (state_r == ADX_ST_BKP && i_wake) begin
         o_backup    <= 1'b0;
         o_vdet_keep <= 1'b1;
      end
   end

   // ----------------------------------------
   // Accumulator transfers and counter
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pc_inc <= 1'b0;
         o_a_we   <= 1'b0;
         o_b_we   <= 1'b0;
         o_a_data <= '0;
         o_b_data <= '0;
      end else begin
         o_pc_inc <= i_valid && (state_r != ADX_ST_BKP);
         o_a_we   <= exec && (d_rd_pair || d_rd_low || d_rd_cctl || d_rd_clk);
         o_b_we   <= exec && d_rd_pair;
         if (exec && d_rd_pair && !mode) begin
            o_b_data <= i_conv_result[9:6];
            o_a_data <= i_conv_result[5:2];
         end else if (exec && d_rd_pair) begin
            o_b_data <= i_conv_result[7:4];
            o_a_data <= i_conv_result[3:0];
         end else if (exec && d_rd_low) begin
            o_a_data <= {i_conv_result[1:0], 2'b00};
         end else if (exec && d_rd_cctl) begin
            o_a_data <= o_conv_control;
         end else if (exec && d_rd_clk) begin
            o_a_data <= o_clock_control;
         end
      end
   end

   // ----------------------------------------
   // Converter registers
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) o_conv_control <= `ADX_CCTL_RST;
      else if (exec && d_wr_cctl) o_conv_control <= i_acc_a;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) o_comparator <= `ADX_CMP_RST;
      else if (exec && d_wr_cmp && mode) o_comparator <= {i_acc_b, i_acc_a};
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_conv_start <= 1'b0;
         o_cmp_start  <= 1'b0;
      end else begin
         o_conv_start <= exec && d_start && !mode;
         o_cmp_start  <= exec && d_start && mode;
      end
   end

   // Done event wins over any clear in the same cycle
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) o_conv_done_flag <= 1'b0;
      else if (i_conv_done) o_conv_done_flag <= 1'b1;
      else if (exec && d_start) o_conv_done_flag <= 1'b0;
      // clear only on skip with enable low
      else if (exec && d_done_test && !i_conv_ie) o_conv_done_flag <= 1'b0;
   end

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) o_wdt_flag_one <= 1'b0;
      else if (i_wdt_flag_set) o_wdt_flag_one <= 1'b1;
      else if (exec && d_wdt_rst) o_wdt_flag_one <= 1'b0;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) o_wdt_stop <= 1'b0;
      else if (exec && d_wdt_rst && wdt_armed_r) o_wdt_stop <= 1'b1;
   end

   // ----------------------------------------
   // Clock control
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_clk_src   <= ADX_CLK_RING;
         o_ring_stop <= 1'b0;
      end else if (exec && d_cer) begin
         o_clk_src   <= ADX_CLK_CERAMIC;
         o_ring_stop <= 1'b1;
      end else if (exec && d_rc) begin
         o_clk_src   <= ADX_CLK_RC;
         o_ring_stop <= 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) o_clock_control <= `ADX_CLK_RST;
      else if (exec && d_wr_clk) o_clock_control <= i_acc_a;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_arm;
      run && d_pd_arm;
   endsequence

   AST_PAIR_CONV: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_rd_pair && !mode |=> o_b_we && o_b_data == $past(i_conv_result[9:6]))
      else $error("pair read conversion mode wrong");
   AST_PAIR_CMP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_rd_pair && mode |=> o_a_data == $past(i_conv_result[3:0]))
      else $error("pair read comparator mode wrong");
   AST_LOW: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_rd_low |=> o_a_we && o_a_data == {$past(i_conv_result[1:0]), 2'b00})
      else $error("low read wrong");
   AST_CMP_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_wr_cmp && !mode |=> $stable(o_comparator))
      else $error("comparator changed in conversion mode");
   AST_START: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_start && !i_conv_done |=> !o_conv_done_flag && o_cmp_start == $past(mode)
         && o_conv_start == !$past(mode))
      else $error("start wrong");
   AST_DONE_NOP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_done_test && i_conv_ie |=> state_r != ADX_ST_SKIP)
      else $error("done test skipped with enable set");
   AST_ARM_ONE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_arm ##1 (i_valid && !d_pd_arm && !d_bkp_vdet && !d_bkp_all)
         ##1 (run && (d_bkp_vdet || d_bkp_all)) |=> !o_backup)
      else $error("stale arm entered backup");
   AST_PD_SKIP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_pd_test && i_pd_flag && !pd_armed_r |=> state_r == ADX_ST_SKIP)
      else $error("power-down test did not skip");
   AST_RING: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_rc |=> o_ring_stop && o_clk_src == ADX_CLK_RC)
      else $error("rc select wrong");

   // Stop enable directly followed by restart
   sequence s_wdt_pair;
      (run && d_wdt_stopen) ##1 (run && d_wdt_rst);
   endsequence

   AST_DONE_SKIP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_done_test && !i_conv_ie && o_conv_done_flag |=> state_r == ADX_ST_SKIP
         && (!o_conv_done_flag || $past(i_conv_done)))
      else $error("done test did not skip and clear");
   AST_NOP_QUIET: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_nop |=> o_pc_inc && !o_a_we && !o_b_we && $stable(o_conv_control)
         && $stable(o_comparator) && $stable(o_clock_control))
      else $error("no-operation changed state");
   AST_BKP_VDET: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_arm ##1 (run && d_bkp_vdet) |=> o_backup && o_vdet_keep && state_r == ADX_ST_BKP)
      else $error("armed backup with detector not entered");
   AST_BKP_ALL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_arm ##1 (run && d_bkp_all) |=> o_backup && !o_vdet_keep && state_r == ADX_ST_BKP)
      else $error("armed all-stop backup not entered");
   AST_WDT_SKIP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_wdt_rst && o_wdt_flag_one |=> state_r == ADX_ST_SKIP
         && (!o_wdt_flag_one || $past(i_wdt_flag_set)))
      else $error("watchdog restart did not skip and clear");
   AST_WDT_STOP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      s_wdt_pair |=> o_wdt_stop)
      else $error("watchdog not stopped after enabled restart");
   AST_CER: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      run && d_cer |=> o_ring_stop && o_clk_src == ADX_CLK_CERAMIC)
      else $error("ceramic select wrong");
   AST_SKIP_MUTE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      state_r == ADX_ST_SKIP && i_valid |=> o_pc_inc && !o_a_we && !o_b_we
         && !o_conv_start && !o_cmp_start && $stable(o_conv_control)
         && $stable(o_comparator) && $stable(o_clock_control))
      else $error("skipped word had an effect");
endmodule // adx_exec

// [tb/tb.sv]
// Self-checking bench for the converter, power, watchdog and clock executor
`timescale 1ns/1ps
`include "adx_map.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module tb;
   import adx_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic           i_mclk;
   logic           i_rst_n;
   logic           i_valid;
   logic [9:0]     i_op;
   logic [3:0]     i_acc_a;
   logic [3:0]     i_acc_b;
   logic [9:0]     i_conv_result;
   logic           i_conv_done;
   logic           i_conv_ie;
   logic           i_pd_flag;
   logic           i_wdt_flag_set;
   logic           i_wake;
   logic           o_pc_inc;
   logic           o_a_we;
   logic [3:0]     o_a_data;
   logic           o_b_we;
   logic [3:0]     o_b_data;
   logic [3:0]     o_conv_control;
   logic [7:0]     o_comparator;
   logic           o_conv_start;
   logic           o_cmp_start;
   logic           o_conv_done_flag;
   logic           o_backup;
   logic           o_vdet_keep;
   logic           o_wdt_flag_one;
   logic           o_wdt_stop;
   adx_clksrc_type o_clk_src;
   logic           o_ring_stop;
   logic [3:0]     o_clock_control;
   int             failures;
   int             n_compared;
   localparam logic [9:0] RES = 10'h2d6;

   adx_exec #(.DATA_W(4)) adx_exec_i (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_op(i_op),
      .i_acc_a(i_acc_a), .i_acc_b(i_acc_b), .i_conv_result(i_conv_result),
      .i_conv_done(i_conv_done), .i_conv_ie(i_conv_ie), .i_pd_flag(i_pd_flag),
      .i_wdt_flag_set(i_wdt_flag_set), .i_wake(i_wake), .o_pc_inc(o_pc_inc),
      .o_a_we(o_a_we), .o_a_data(o_a_data), .o_b_we(o_b_we), .o_b_data(o_b_data),
      .o_conv_control(o_conv_control), .o_comparator(o_comparator),
      .o_conv_start(o_conv_start), .o_cmp_start(o_cmp_start),
      .o_conv_done_flag(o_conv_done_flag), .o_backup(o_backup),
      .o_vdet_keep(o_vdet_keep), .o_wdt_flag_one(o_wdt_flag_one),
      .o_wdt_stop(o_wdt_stop), .o_clk_src(o_clk_src), .o_ring_stop(o_ring_stop),
      .o_clock_control(o_clock_control)
   );

   // ----------------------------------------
   // Clock and access tasks
   // ----------------------------------------
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // Word stays valid on exit; effects are visible right after return
   task automatic iss(input logic [9:0] op, input logic [3:0] a, input logic [3:0] b);
      i_valid = 1'b1;
      i_op = op;
      i_acc_a = a;
      i_acc_b = b;
      i_conv_done = 1'b0;
      i_wdt_flag_set = 1'b0;
      i_wake = 1'b0;
      @(posedge i_mclk);
      #1;
   endtask

   // Idle cycle carrying the event inputs
   task automatic tick(input logic d, input logic w, input logic k);
      i_valid = 1'b0;
      i_conv_done = d;
      i_wdt_flag_set = w;
      i_wake = k;
      @(posedge i_mclk);
      #1;
   endtask

   task automatic end_of_test();
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Guards against a hang
   initial begin
      #20000;
      failures++;
      end_of_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      failures = 0;
      n_compared = 0;
      i_rst_n = 1'b0;
      i_valid = 1'b0;
      i_op = `ADX_OP_NOP;
      i_acc_a = 4'h0;
      i_acc_b = 4'h0;
      i_conv_result = RES;
      i_conv_done = 1'b0;
      i_conv_ie = 1'b0;
      i_pd_flag = 1'b0;
      i_wdt_flag_set = 1'b0;
      i_wake = 1'b0;
      repeat (2) @(posedge i_mclk);
      #1;
      i_rst_n = 1'b1;
      `CHK(o_vdet_keep, 1'b1)
      `CHK(o_clk_src, ADX_CLK_RING)
      `CHK(o_comparator, `ADX_CMP_RST)
      // Both converter modes, back to back words
      for (int m = 0; m < 2; m++) begin
         iss(`ADX_OP_WR_CCTL, (m == 1) ? 4'h8 : 4'h3, 4'h0);
         iss(`ADX_OP_RD_CCTL, 4'h0, 4'h0);
         `CHK(o_a_we, 1'b1)
         `CHK(o_a_data, (m == 1) ? 4'h8 : 4'h3)
         iss(`ADX_OP_RD_PAIR, 4'h0, 4'h0);
         `CHK({o_b_we, o_a_we}, 2'b11)
         `CHK(o_b_data, (m == 1) ? RES[7:4] : RES[9:6])
         `CHK(o_a_data, (m == 1) ? RES[3:0] : RES[5:2])
         iss(`ADX_OP_RD_LOW, 4'h0, 4'h0);
         `CHK(o_a_data, {RES[1:0], 2'h0})
         iss(`ADX_OP_WR_CMP, 4'h9, 4'h6);
         `CHK(o_pc_inc, 1'b1)
         `CHK(o_comparator, (m == 1) ? 8'h69 : 8'h00)
         tick(1'b1, 1'b0, 1'b0);
         `CHK(o_conv_done_flag, 1'b1)
         iss(`ADX_OP_CONV_START, 4'h0, 4'h0);
         `CHK(o_conv_done_flag, 1'b0)
         `CHK({o_conv_start, o_cmp_start}, (m == 1) ? 2'b01 : 2'b10)
      end
      // Done test with enable low: flag set skips, flag clear executes
      tick(1'b1, 1'b0, 1'b0);
      iss(`ADX_OP_DONE_TEST, 4'h0, 4'h0);
      iss(`ADX_OP_WR_CCTL, 4'h5, 4'h0);
      `CHK(o_pc_inc, 1'b1)
      `CHK(o_conv_control, 4'h8)
      `CHK(o_conv_done_flag, 1'b0)
      iss(`ADX_OP_DONE_TEST, 4'h0, 4'h0);
      iss(`ADX_OP_WR_CCTL, 4'h5, 4'h0);
      `CHK(o_conv_control, 4'h5)
      // Done test with enable high acts as no-operation
      i_conv_ie = 1'b1;
      tick(1'b1, 1'b0, 1'b0);
      iss(`ADX_OP_DONE_TEST, 4'h0, 4'h0);
      `CHK(o_conv_done_flag, 1'b1)
      iss(`ADX_OP_WR_CCTL, 4'h2, 4'h0);
      `CHK(o_conv_control, 4'h2)
      iss(`ADX_OP_NOP, 4'hf, 4'hf);
      `CHK({o_pc_inc, o_a_we, o_b_we, o_conv_start, o_cmp_start}, 5'b10000)
      `CHK({o_conv_control, o_comparator}, 12'h269)
      // Arming only covers the very next word
      iss(`ADX_OP_BKP_ALL, 4'h0, 4'h0);
      `CHK(o_backup, 1'b0)
      iss(`ADX_OP_PD_ARM, 4'h0, 4'h0);
      iss(`ADX_OP_NOP, 4'h0, 4'h0);
      iss(`ADX_OP_BKP_VDET, 4'h0, 4'h0);
      `CHK(o_backup, 1'b0)
      iss(`ADX_OP_PD_ARM, 4'h0, 4'h0);
      iss(`ADX_OP_BKP_ALL, 4'h0, 4'h0);
      `CHK({o_backup, o_vdet_keep}, 2'b10)
      iss(`ADX_OP_RD_CCTL, 4'h0, 4'h0);
      `CHK({o_pc_inc, o_a_we}, 2'b00)
      tick(1'b0, 1'b0, 1'b1);
      tick(1'b0, 1'b0, 1'b0);
      `CHK(o_backup, 1'b0)
      iss(`ADX_OP_PD_ARM, 4'h0, 4'h0);
      iss(`ADX_OP_BKP_VDET, 4'h0, 4'h0);
      `CHK({o_backup, o_vdet_keep}, 2'b11)
      tick(1'b0, 1'b0, 1'b1);
      tick(1'b0, 1'b0, 1'b0);
      `CHK(o_backup, 1'b0)
      // Power-down flag test
      i_pd_flag = 1'b1;
      iss(`ADX_OP_PD_TEST, 4'h0, 4'h0);
      iss(`ADX_OP_WR_CLK, 4'h7, 4'h0);
      `CHK(o_clock_control, `ADX_CLK_RST)
      iss(`ADX_OP_PD_TEST, 4'h0, 4'h0);
      iss(`ADX_OP_WR_CLK, 4'h7, 4'h0);
      `CHK(o_clock_control, `ADX_CLK_RST)
      i_pd_flag = 1'b0;
      iss(`ADX_OP_PD_TEST, 4'h0, 4'h0);
      iss(`ADX_OP_WR_CLK, 4'ha, 4'h0);
      `CHK(o_clock_control, 4'ha)
      iss(`ADX_OP_RD_CLK, 4'h0, 4'h0);
      `CHK({o_a_we, o_a_data}, 5'h1a)
      // Watchdog restart skip and stop sequence
      tick(1'b0, 1'b1, 1'b0);
      `CHK(o_wdt_flag_one, 1'b1)
      iss(`ADX_OP_WDT_RST, 4'h0, 4'h0);
      iss(`ADX_OP_WR_CLK, 4'h3, 4'h0);
      `CHK(o_clock_control, 4'ha)
      `CHK(o_wdt_flag_one, 1'b0)
      iss(`ADX_OP_WDT_RST, 4'h0, 4'h0);
      iss(`ADX_OP_WR_CLK, 4'h3, 4'h0);
      `CHK(o_clock_control, 4'h3)
      `CHK(o_wdt_stop, 1'b0)
      iss(`ADX_OP_WDT_STOPEN, 4'h0, 4'h0);
      iss(`ADX_OP_NOP, 4'h0, 4'h0);
      iss(`ADX_OP_WDT_RST, 4'h0, 4'h0);
      `CHK(o_wdt_stop, 1'b0)
      iss(`ADX_OP_WDT_STOPEN, 4'h0, 4'h0);
      iss(`ADX_OP_WDT_RST, 4'h0, 4'h0);
      tick(1'b0, 1'b0, 1'b0);
      `CHK(o_wdt_stop, 1'b1)
      // Oscillator selection
      iss(`ADX_OP_CER_SEL, 4'h0, 4'h0);
      `CHK(o_clk_src, ADX_CLK_CERAMIC)
      `CHK(o_ring_stop, 1'b1)
      iss(`ADX_OP_RC_SEL, 4'h0, 4'h0);
      tick(1'b0, 1'b0, 1'b0);
      `CHK(o_clk_src, ADX_CLK_RC)
      `CHK(o_ring_stop, 1'b1)
      end_of_test();
   end
endmodule // tb
